// >>> common/sfr_pkg.sv
// Shared constants and types of the serial flash command decoder
package sfr_pkg;
    // Command opcodes
    localparam logic [7:0] OPC_READ_FAST   = 8'h0B;
    localparam logic [7:0] OPC_READ_SLOW   = 8'h03;
    localparam logic [7:0] OPC_PAGE_READ   = 8'hD2;
    localparam logic [7:0] OPC_BUF_RD_FAST = 8'hD4;
    localparam logic [7:0] OPC_BUF_RD_SLOW = 8'hD1;
    localparam logic [7:0] OPC_BUF_WRITE   = 8'h84;
    localparam logic [7:0] OPC_PROG_ERASE  = 8'h83;

    // Last bit index of each header field
    localparam logic [5:0] OPC_LAST_BIT    = 6'h07;
    localparam logic [5:0] ADDR_LAST_BIT   = 6'h17;
    localparam logic [5:0] DUMMY_LAST_ONE  = 6'h07;
    localparam logic [5:0] DUMMY_LAST_FOUR = 6'h1F;

    // Page and buffer geometry
    localparam int         BUF_BYTES     = 264;
    localparam logic [8:0] LAST_BYTE_264 = 9'h107;
    localparam logic [8:0] LAST_BYTE_256 = 9'h0FF;
    localparam logic [9:0] LAST_PAGE     = 10'h3FF;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    // Values after reset
    localparam logic       PS256_RESET  = 1'h0;
    localparam logic       OE_N_RESET   = 1'h1;
    localparam logic [2:0] SCK_SYNC_RST = 3'h0;
    localparam logic [2:0] CSN_SYNC_RST = 3'h7;

    // Command sequencer, Gray along opcode, address, dummy, data
    typedef enum logic [2:0] {
        ST_OPC   = 3'h0,
        ST_ADDR  = 3'h1,
        ST_DUMMY = 3'h3,
        ST_RDATA = 3'h2,
        ST_WDATA = 3'h6,
        ST_SKIP  = 3'h7
    } sfr_state_t;

    // Self-timed erase and program engine
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'h0,
        ENG_ERASE = 2'h1,
        ENG_COPY  = 2'h3
    } sfr_eng_t;
endpackage

// >>> common/sfr_link_if.sv
// Sampled serial link events passed from synchroniser to core
`timescale 1ns/10ps
interface sfr_link_if;
    logic sck_rise; // Serial clock rising edge, one cycle
    logic sck_fall; // Serial clock falling edge, one cycle
    logic cs_act;   // Chip select asserted, level
    logic cs_start; // Chip select falling edge, one cycle
    logic cs_end;   // Chip select rising edge, one cycle
    logic si_bit;   // Serial input aligned with the edges

    modport sync (output sck_rise, sck_fall, cs_act, cs_start, cs_end, si_bit);
    modport core (input sck_rise, sck_fall, cs_act, cs_start, cs_end, si_bit);
endinterface

// >>> core/sfr_link_sync.sv
// Pin synchronisers and edge detection for the serial link
`timescale 1ns/10ps
module sfr_link_sync
    import sfr_pkg::*;
(
    input  wire logic clk,      // System clock
    input  wire logic rst_n,    // Async reset, active low
    input  wire logic sck_pin,  // Serial clock pin
    input  wire logic cs_n_pin, // Chip select pin, active low
    input  wire logic si_pin,   // Serial data pin
    sfr_link_if.sync  lnk       // Sampled events
);
    logic [2:0] sck_q;
    logic [2:0] csn_q;
    logic [1:0] si_q;

    // Two flops per pin, third stage only for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= SCK_SYNC_RST;
            csn_q <= CSN_SYNC_RST;
            si_q  <= 2'h0;
        end else begin
            sck_q <= {sck_q[1:0], sck_pin};
            csn_q <= {csn_q[1:0], cs_n_pin};
            si_q  <= {si_q[0], si_pin};
        end
    end

    // Clock edges only count while selected
    assign lnk.cs_act   = !csn_q[1];
    assign lnk.cs_start = !csn_q[1] && csn_q[2];
    assign lnk.cs_end   = csn_q[1] && !csn_q[2];
    assign lnk.sck_rise = !csn_q[1] && sck_q[1] && !sck_q[2];
    assign lnk.sck_fall = !csn_q[1] && !sck_q[1] && sck_q[2];
    assign lnk.si_bit   = si_q[1];
endmodule // sfr_link_sync

// >>> core/sfr_buffer.sv
// Data buffer held in flip-flops, one write and one read port
`timescale 1ns/10ps
module sfr_buffer
    import sfr_pkg::*;
(
    input  wire logic       clk,   // System clock
    input  wire logic       we,    // Write strobe
    input  wire logic [8:0] widx,  // Write index
    input  wire logic [7:0] wdata, // Write byte
    input  wire logic [8:0] ridx,  // Read index
    output logic      [7:0] rdata  // Read byte
);
    logic [7:0] mem_q [BUF_BYTES];

    // Contents are data, not control, so no reset
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[widx] <= wdata;
        end
    end

    assign rdata = mem_q[ridx];
endmodule // sfr_buffer

// >>> core/sfr_top.sv
// Serial flash read, buffer and program command decoder
`timescale 1ns/10ps
module sfr_top
    import sfr_pkg::*;
(
    input  wire logic        CLOCK,       // System clock, 10 MHz
    input  wire logic        NRST,        // Async reset, active low
    input  wire logic        SCK,         // Serial clock pin
    input  wire logic        CS_N,        // Chip select pin, active low
    input  wire logic        SI,          // Serial data in pin
    output logic             SO,          // Serial data out
    output logic             SO_OE_N,     // Serial out enable, low drives
    input  wire logic        PAGE_256,    // Page size setting, 1 = 256
    output logic             BUSY,        // Erase and program running
    output logic      [18:0] ARRAY_ADDR,  // Array page and byte
    output logic             ARRAY_RD,    // Array read strobe
    input  wire logic [7:0]  ARRAY_RDATA, // Array byte, cycle after strobe
    output logic             ARRAY_WR,    // Array write strobe
    output logic      [7:0]  ARRAY_WDATA  // Array write byte
);
    sfr_link_if link ();

    sfr_state_t  state_q;
    sfr_eng_t    eng_q;
    logic [5:0]  cnt_q;
    logic [23:0] sh_q;
    logic [23:0] sh_d;
    logic [7:0]  opc_q;
    logic [5:0]  dlast_q;
    logic        src_buf_q;
    logic        pread_q;
    logic [9:0]  page_q;
    logic [8:0]  byte_q;
    logic [2:0]  obit_q;
    logic [7:0]  dat_q;
    logic        fetch_q;
    logic        ld_q;
    logic        so_q;
    logic        oe_n_q;
    logic        arm_q;
    logic        ps_s1_q;
    logic        ps_s2_q;
    logic        ps256_q;
    logic [8:0]  eng_idx_q;
    logic [9:0]  prog_page_q;
    logic [9:0]  a_page;
    logic [8:0]  a_byte;
    logic [8:0]  last_byte;
    logic        rise;
    logic        fall;
    logic        opc_end;
    logic        addr_end;
    logic        enter_rd;
    logic        adv;
    logic        byte_wrap;
    logic        buf_we;
    logic        known_opc;
    logic        cont_rd;
    logic        busy;
    logic [7:0]  buf_rdata;
    logic [8:0]  buf_ridx;

    sfr_link_sync u_sync (
        .clk      (CLOCK),
        .rst_n    (NRST),
        .sck_pin  (SCK),
        .cs_n_pin (CS_N),
        .si_pin   (SI),
        .lnk      (link)
    );

    sfr_buffer u_buf (
        .clk   (CLOCK),
        .we    (buf_we),
        .widx  (byte_q),
        .wdata (sh_d[7:0]),
        .ridx  (buf_ridx),
        .rdata (buf_rdata)
    );

    // Edges only arrive while selected, so stray clocks are harmless
    assign rise = link.sck_rise;
    assign fall = link.sck_fall;
    assign sh_d = {sh_q[22:0], link.si_bit};

    // Address split follows the held page-size setting
    assign last_byte = ps256_q ? LAST_BYTE_256 : LAST_BYTE_264;
    assign a_page = ps256_q ? sh_d[17:8] : sh_d[18:9];
    assign a_byte = ps256_q ? {1'b0, sh_d[7:0]} : sh_d[8:0];

    // Header and stream events
    assign opc_end   = rise && state_q == ST_OPC && cnt_q == OPC_LAST_BIT;
    assign addr_end  = rise && state_q == ST_ADDR && cnt_q == ADDR_LAST_BIT;
    assign enter_rd  = (addr_end && opc_q == OPC_READ_SLOW)
                    || (rise && state_q == ST_DUMMY && cnt_q == dlast_q);
    assign adv       = fall && state_q == ST_RDATA && obit_q == 3'h7;
    assign byte_wrap = byte_q == last_byte;
    assign cont_rd   = !src_buf_q && !pread_q;
    assign busy      = eng_q != ENG_IDLE;

    // Only a completed byte in write state reaches the buffer
    assign buf_we   = rise && state_q == ST_WDATA && cnt_q[2:0] == 3'h7;
    assign buf_ridx = busy ? eng_idx_q : byte_q;

    // Opcodes this decoder answers
    always_comb begin
        case (sh_d[7:0])
            OPC_READ_FAST,
            OPC_READ_SLOW,
            OPC_PAGE_READ,
            OPC_BUF_RD_FAST,
            OPC_BUF_RD_SLOW,
            OPC_BUF_WRITE,
            OPC_PROG_ERASE: known_opc = 1'b1;
            default:        known_opc = 1'b0;
        endcase
    end

    // Page-size setting: synchronised, held steady during commands
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ps_s1_q <= 1'b0;
            ps_s2_q <= 1'b0;
            ps256_q <= PS256_RESET;
        end else begin
            ps_s1_q <= PAGE_256;
            ps_s2_q <= ps_s1_q;
            if (!link.cs_act && !busy) begin
                ps256_q <= ps_s2_q;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_OPC;
            cnt_q   <= 6'h00;
        end else if (link.cs_start || link.cs_end) begin
            state_q <= ST_OPC;
            cnt_q   <= 6'h00;
        end else if (rise) begin
            cnt_q <= cnt_q + 6'h01;
            case (state_q)
                ST_OPC: begin
                    if (opc_end) begin
                        cnt_q   <= 6'h00;
                        // Commands are ignored while the engine owns the array
                        state_q <= (known_opc && !busy) ? ST_ADDR : ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (addr_end) begin
                        cnt_q <= 6'h00;
                        case (opc_q)
                            OPC_READ_SLOW:  state_q <= ST_RDATA;
                            OPC_BUF_WRITE:  state_q <= ST_WDATA;
                            OPC_PROG_ERASE: state_q <= ST_SKIP;
                            default:        state_q <= ST_DUMMY;
                        endcase
                    end
                end
                ST_DUMMY: begin
                    if (cnt_q == dlast_q) begin
                        cnt_q   <= 6'h00;
                        state_q <= ST_RDATA;
                    end
                end
                ST_WDATA: begin
                    if (cnt_q[2:0] == 3'h7) begin
                        cnt_q <= 6'h00;
                    end
                end
                default: begin
                    cnt_q <= cnt_q;
                end
            endcase
        end
    end

    // Shift register for opcode, address and write data
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sh_q <= 24'h000000;
        end else if (rise) begin
            sh_q <= sh_d;
        end
    end

    // Command attributes latched with the opcode
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            opc_q     <= 8'h00;
            dlast_q   <= DUMMY_LAST_ONE;
            src_buf_q <= 1'b0;
            pread_q   <= 1'b0;
        end else if (opc_end) begin
            opc_q     <= sh_d[7:0];
            // Page read needs four ignored bytes; fast read and both buffer reads need one, slow read none
            dlast_q   <= (sh_d[7:0] == OPC_PAGE_READ) ? DUMMY_LAST_FOUR
                                                      : DUMMY_LAST_ONE;
            src_buf_q <= sh_d[7:0] == OPC_BUF_RD_FAST
                      || sh_d[7:0] == OPC_BUF_RD_SLOW;
            pread_q   <= sh_d[7:0] == OPC_PAGE_READ;
        end
    end

    // Page and byte position, shared by array and buffer commands
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            page_q <= 10'h000;
            byte_q <= 9'h000;
        end else if (addr_end) begin
            page_q <= a_page;
            byte_q <= a_byte;
        end else if (adv || buf_we) begin
            if (byte_wrap) begin
                byte_q <= 9'h000;
                if (adv && cont_rd) begin
                    // Page counter rolls over at the array end by itself
                    page_q <= page_q + 10'h001;
                end
            end else begin
                byte_q <= byte_q + 9'h001;
            end
        end
    end

    // Prefetch: a byte is fetched on the edge that ends the header or shifts out the previous byte's last bit
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            fetch_q <= 1'b0;
            ld_q    <= 1'b0;
        end else begin
            fetch_q <= enter_rd || adv;
            ld_q    <= fetch_q && !src_buf_q;
        end
    end

    // Byte about to be shifted out
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            dat_q <= 8'h00;
        end else if (fetch_q && src_buf_q) begin
            dat_q <= buf_rdata;
        end else if (ld_q) begin
            dat_q <= ARRAY_RDATA;
        end
    end

    // Serial output: new bit on each falling edge, released at deselect
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            so_q   <= 1'b0;
            oe_n_q <= OE_N_RESET;
            obit_q <= 3'h0;
        end else if (link.cs_end || link.cs_start) begin
            oe_n_q <= OE_N_RESET;
            obit_q <= 3'h0;
        end else if (enter_rd) begin
            oe_n_q <= 1'b0;
            obit_q <= 3'h0;
        end else if (fall && state_q == ST_RDATA) begin
            so_q   <= dat_q[3'h7 - obit_q];
            obit_q <= obit_q + 3'h1;
        end
    end

    // Program request armed by a complete 83 header
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            arm_q <= 1'b0;
        end else if (link.cs_start || link.cs_end) begin
            arm_q <= 1'b0;
        end else if (addr_end && opc_q == OPC_PROG_ERASE) begin
            arm_q <= 1'b1;
        end
    end

    // Self-timed engine: erase pass then copy pass, one byte a cycle
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            eng_q       <= ENG_IDLE;
            eng_idx_q   <= 9'h000;
            prog_page_q <= 10'h000;
        end else begin
            case (eng_q)
                ENG_IDLE: begin
                    if (link.cs_end && arm_q) begin
                        eng_q       <= ENG_ERASE;
                        eng_idx_q   <= 9'h000;
                        prog_page_q <= page_q;
                    end
                end
                ENG_ERASE: begin
                    if (eng_idx_q == last_byte) begin
                        eng_q     <= ENG_COPY;
                        eng_idx_q <= 9'h000;
                    end else begin
                        eng_idx_q <= eng_idx_q + 9'h001;
                    end
                end
                ENG_COPY: begin
                    if (eng_idx_q == last_byte) begin
                        eng_q <= ENG_IDLE;
                    end else begin
                        eng_idx_q <= eng_idx_q + 9'h001;
                    end
                end
                default: begin
                    eng_q <= ENG_IDLE;
                end
            endcase
        end
    end

    // Array port belongs to the engine while busy
    assign ARRAY_ADDR  = busy ? {prog_page_q, eng_idx_q} : {page_q, byte_q};
    assign ARRAY_RD    = fetch_q && !src_buf_q;
    assign ARRAY_WR    = busy;
    assign ARRAY_WDATA = (eng_q == ENG_ERASE) ? ERASED_BYTE : buf_rdata;
    assign BUSY        = busy;
    assign SO          = so_q;
    assign SO_OE_N     = oe_n_q;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    sequence s_last_adv;
        adv && byte_wrap;
    endsequence

    sequence s_prog_start;
        eng_q == ENG_IDLE && link.cs_end && arm_q;
    endsequence

    chk_cs_release: assert property (
        link.cs_end |=> SO_OE_N && state_q == ST_OPC)
        else $error("output not released at deselect");

    chk_page_cross: assert property (
        s_last_adv ##0 cont_rd |=> byte_q == 9'h000 && page_q == $past(page_q) + 10'h001)
        else $error("continuous read did not step to next page");

    chk_array_wrap: assert property (
        s_last_adv ##0 (cont_rd && page_q == LAST_PAGE) |=> page_q == 10'h000)
        else $error("continuous read did not wrap to page zero");

    chk_same_page: assert property (
        s_last_adv ##0 pread_q |=> byte_q == 9'h000 && $stable(page_q))
        else $error("page read left its page");

    chk_buf_rd_wrap: assert property (
        s_last_adv ##0 src_buf_q |=> byte_q == 9'h000)
        else $error("buffer read did not wrap");

    chk_buf_wr_wrap: assert property (
        buf_we && byte_wrap |=> byte_q == 9'h000 && state_q == ST_WDATA)
        else $error("buffer write did not wrap");

    chk_read_no_write: assert property (
        state_q == ST_RDATA |-> !buf_we)
        else $error("read touched the buffer");

    chk_erase_first: assert property (
        s_prog_start |=> ARRAY_WR && ARRAY_WDATA == ERASED_BYTE && eng_idx_q == 9'h000)
        else $error("program did not begin with erase");

    chk_busy_held: assert property (
        s_prog_start |=> BUSY [*8])
        else $error("busy dropped early");

    chk_msb_first: assert property (
        fall && state_q == ST_RDATA && obit_q == 3'h0 |=> SO == $past(dat_q[7]))
        else $error("first bit out is not the top bit");

    chk_slow_no_dummy: assert property (
        addr_end && opc_q == OPC_READ_SLOW |=> state_q == ST_RDATA && !SO_OE_N)
        else $error("slow read did not start data at once");

    chk_fast_dummy: assert property (
        addr_end && opc_q == OPC_READ_FAST |=> state_q == ST_DUMMY && dlast_q == DUMMY_LAST_ONE)
        else $error("fast read skipped its dummy byte");

    chk_split_264: assert property (
        addr_end && !ps256_q |=> page_q == $past(sh_d[18:9]) && byte_q == $past(sh_d[8:0]))
        else $error("264-byte address split wrong");

    chk_split_256: assert property (
        addr_end && ps256_q |=> page_q == $past(sh_d[17:8]) && byte_q[8] == 1'b0)
        else $error("256-byte address split wrong");
endmodule // sfr_top

// >>> verification/sfr_host.sv
// Host model driving the serial link in clock mode 0 or 3
`timescale 1ns/10ps
module sfr_host (
    input  wire logic clk,  // System clock
    output logic      sck,  // Serial clock
    output logic      cs_n, // Chip select, active low
    output logic      si,   // Serial data to device
    input  wire logic so    // Serial data from device
);
    logic cpol = 1'b0; // Idle clock level, high selects mode 3

    // Idle: clock stands still, released data line keeps changing
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        forever begin
            @(negedge clk);
            if (cs_n) si = ~si;
        end
    end
    // Whole system cycles, counted at the falling edge
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Select falls before the first clock
    task automatic open_f();
        cs_n = 1'b0;
        wt(4);
    endtask
    // MSB first; sample just before the fall, when output is steady
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            if (cpol) sck = 1'b0;
            si = d[i];
            wt(4);
            sck = 1'b1;
            wt(4);
            q[i] = so;
            if (!cpol) sck = 1'b0;
        end
    endtask
    // Idle clock level, changed only between frames
    task automatic set_mode(input logic m);
        cpol = m;
        sck = m;
    endtask
    // Select held low through all data, raised after the last fall
    task automatic close_f(input int tail);
        wt(4);
        cs_n = 1'b1;
        wt(tail);
    endtask
endmodule // sfr_host

// >>> verification/sfr_top_bench.sv
// Self-checking bench of the serial flash command decoder
`timescale 1ns/10ps
module sfr_top_bench;
    import sfr_pkg::*;
    logic        clk, nrst, sck, cs_n, si, so, so_oe_n, p256, busy, ard, awr;
    logic [18:0] aadr;
    logic [7:0]  ardata, awdata, q;
    logic [7:0]  bufm [BUF_BYTES];
    logic [7:0]  ops [3] = '{OPC_READ_SLOW, OPC_READ_FAST, OPC_PAGE_READ};
    int          nds [3] = '{0, 1, 4};
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;

    sfr_top dut_u (.CLOCK(clk), .NRST(nrst), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so),
        .SO_OE_N(so_oe_n), .PAGE_256(p256), .BUSY(busy), .ARRAY_ADDR(aadr), .ARRAY_RD(ard),
        .ARRAY_RDATA(ardata), .ARRAY_WR(awr), .ARRAY_WDATA(awdata));
    sfr_host host_u (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Scrambled array content, so a wrong page or byte shows
    function automatic logic [7:0] adat(input logic [18:0] a);
        return a[7:0] ^ a[15:8] ^ {5'h0, a[18:16]} ^ 8'h5A;
    endfunction
    logic        ard_q = 1'b0;
    logic [18:0] aadr_q = '0;
    // Array answers in the cycle after the strobe, garbage otherwise
    always @(negedge clk) begin
        ardata <= ard_q ? adat(aadr_q) : ~ardata;
        ard_q  <= ard;
        aadr_q <= aadr;
    end
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [18:0] g, input logic [18:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Kind: 0 continuous, 1 page, 2 buffer, 3 refused opcode
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd, n, kd);
        logic [9:0] pg;
        logic [8:0] by, lst;
        logic [7:0] e;
        pg = p256 ? a[17:8] : a[18:9];
        by = p256 ? {1'b0, a[7:0]} : a[8:0];
        lst = p256 ? LAST_BYTE_256 : LAST_BYTE_264;
        host_u.open_f();
        host_u.xb(op, q);
        for (int i = 0; i < 3 + nd; i++) host_u.xb(i < 3 ? a[23-8*i -: 8] : 8'($urandom), q);
        for (int i = 0; i < n; i++) begin
            host_u.xb(8'($urandom), q);
            e = kd == 2 ? bufm[by] : adat({pg, by});
            chk(so_oe_n, 19'(kd == 3));
            if (kd != 3) chk(q, e);
            if (by == lst) begin
                by = '0;
                if (kd == 0) pg++;
            end else by++;
        end
        host_u.close_f(8);
        chk(so_oe_n, 1'b1);
    endtask
    // Buffer write in 264-byte mode from offset o
    task automatic wr(input logic [8:0] o, input int n);
        logic [7:0] d;
        host_u.open_f();
        host_u.xb(OPC_BUF_WRITE, q);
        for (int i = 0; i < 3; i++) host_u.xb(i < 2 ? {7'h0, i == 1 & o[8]} : o[7:0], q);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            host_u.xb(d, q);
            bufm[o] = d;
            o = (o == LAST_BYTE_264) ? 9'h000 : o + 9'h001;
        end
        host_u.close_f(8);
    endtask
    // Program with erase; every engine cycle is checked
    task automatic prog(input logic [9:0] pg);
        int l;
        logic [23:0] a;
        l = p256 ? 256 : 264;
        a = p256 ? {6'h0, pg, 8'h00} : {5'h0, pg, 9'h000};
        host_u.open_f();
        host_u.xb(OPC_PROG_ERASE, q);
        for (int i = 0; i < 3; i++) host_u.xb(a[23-8*i -: 8], q);
        host_u.close_f(0);
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 2 * l; i++) begin
            chk({busy, awr}, 2'h3);
            chk(aadr, {pg, 9'(i % l)});
            chk(awdata, i < l ? ERASED_BYTE : bufm[i - l]);
            @(negedge clk);
        end
        chk({busy, awr}, 2'h0);
    endtask

    initial begin
        logic [9:0] pg;
        void'($urandom(32'hDABCC8F3));
        nrst = 1'b0;
        p256 = 1'b0;
        ardata = 8'h00;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        wr(9'h002, 266);
        rd(OPC_BUF_RD_FAST, 24'h000106, 1, 4, 2);
        // Both page sizes, reads across page end and array end, modes 0 then 3
        for (int m = 0; m < 4; m++) begin
            p256 = m[0];
            host_u.set_mode(m[1]);
            repeat (6) @(negedge clk);
            pg = m > 1 ? LAST_PAGE : 10'($urandom);
            for (int k = 0; k < 3; k++)
                rd(ops[k], p256 ? {6'h0, pg, 8'hFE} : {5'h0, pg, 9'h106}, nds[k], 4, k / 2);
        end
        rd(8'h55, 24'h000000, 0, 2, 3);
        rd(OPC_BUF_RD_SLOW, 24'h0000FE, 1, 4, 2);
        for (int m = 0; m < 2; m++) begin
            p256 = m[0];
            repeat (6) @(negedge clk);
            prog(10'($urandom));
        end
        stop_test();
    end
endmodule // sfr_top_bench
